/* File: logic/tag_interrupt_flag_unit.sv */
// Pending-interrupt flags and enables of the tag, reached over the
// two-wire serial register port, with the interrupt output pin.
// Assumes event inputs are one-cycle pulses on mclk and that scl/sda
// come from pins, asynchronous to mclk.
module tag_interrupt_flag_unit (
   input  wire logic                      mclk,
   input  wire logic                      reset,
   input  wire logic                      scl,
   input  wire logic                      sda_i,
   output logic                           sda_o,
   output logic                           sda_oe,
   input  wire tag_irq_pkg::tag_events_t  events,
   input  wire logic                      parity_mode_en,
   output logic                           irq
);

   tag_irq_pkg::unit_state_t q;
   tag_irq_pkg::unit_state_t d;
   logic        scl_lvl;
   logic        scl_rise;
   logic        scl_fall;
   logic        sda_lvl;
   logic        sda_rise;
   logic        sda_fall;
   logic        wr_en;
   logic [15:0] clr;
   logic [15:0] set;
   logic [15:0] ena_new;
   logic [7:0]  rx_byte;

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   pin_sync u_scl (
      .mclk  (mclk),
      .reset (reset),
      .pin   (scl),
      .level (scl_lvl),
      .rise  (scl_rise),
      .fall  (scl_fall)
   );

   pin_sync u_sda (
      .mclk  (mclk),
      .reset (reset),
      .pin   (sda_i),
      .level (sda_lvl),
      .rise  (sda_rise),
      .fall  (sda_fall)
   );

   // ---------------------------------------------------------------
   // Register read decode
   // ---------------------------------------------------------------
   // Returns the byte at a register address; unmapped bytes read zero.
   function automatic logic [7:0] rd_byte(input logic [15:0] a,
                                          input logic [15:0] fl,
                                          input logic [15:0] en);
      logic [7:0] r;
      r = tag_irq_pkg::BYTE_ZERO;
      unique case (a)
         tag_irq_pkg::FLAG_LO_ADDR: r = fl[7:0];
         tag_irq_pkg::FLAG_HI_ADDR: r = fl[15:8];
         tag_irq_pkg::ENA_LO_ADDR:  r = en[7:0];
         tag_irq_pkg::ENA_HI_ADDR:  r = en[15:8];
         default:                   r = tag_irq_pkg::BYTE_ZERO;
      endcase
      return r;
   endfunction

   assign rx_byte = q.sh;

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   // Serial port state machine, register writes and flag update.
   always_comb begin
      d       = q;
      wr_en   = 1'b0;
      clr     = tag_irq_pkg::FLAG_RESET;
      set     = tag_irq_pkg::FLAG_RESET;
      ena_new = q.ena;
      d.sda_o = 1'b0;

      unique case (q.st)
         tag_irq_pkg::S_IDLE: begin
            d.sda_oe = 1'b0;
         end
         tag_irq_pkg::S_ADDR: begin
            if (scl_rise) begin
               d.sh  = {q.sh[6:0], sda_lvl};
               d.cnt = q.cnt + 4'h1;
            end else if (scl_fall && q.cnt == tag_irq_pkg::BYTE_BITS) begin
               if (q.sh[7:1] == tag_irq_pkg::DEV_ADDR) begin
                  d.rw     = q.sh[0];
                  d.sda_oe = 1'b1;
                  d.st     = tag_irq_pkg::S_ACK_A;
               end else begin
                  d.st = tag_irq_pkg::S_IDLE;
               end
            end
         end
         tag_irq_pkg::S_ACK_A: begin
            if (scl_fall) begin
               d.cnt = tag_irq_pkg::CNT_ZERO;
               if (q.rw) begin
                  d.sh     = rd_byte(q.ptr, q.flags, q.ena);
                  d.sda_oe = ~d.sh[7];
                  d.ptr    = q.ptr + 16'h0001;
                  d.st     = tag_irq_pkg::S_TX;
               end else begin
                  d.sda_oe = 1'b0;
                  d.bidx   = tag_irq_pkg::IDX_PTR_HI;
                  d.st     = tag_irq_pkg::S_RX;
               end
            end
         end
         tag_irq_pkg::S_RX: begin
            if (scl_rise) begin
               d.sh  = {q.sh[6:0], sda_lvl};
               d.cnt = q.cnt + 4'h1;
            end else if (scl_fall && q.cnt == tag_irq_pkg::BYTE_BITS) begin
               d.sda_oe = 1'b1;
               d.st     = tag_irq_pkg::S_ACK_R;
               unique case (q.bidx)
                  tag_irq_pkg::IDX_PTR_HI: begin
                     d.ptr[15:8] = rx_byte;
                     d.bidx      = tag_irq_pkg::IDX_PTR_LO;
                  end
                  tag_irq_pkg::IDX_PTR_LO: begin
                     d.ptr[7:0] = rx_byte;
                     d.bidx     = tag_irq_pkg::IDX_DATA;
                  end
                  default: begin
                     wr_en = 1'b1;
                     d.ptr = q.ptr + 16'h0001;
                  end
               endcase
            end
         end
         tag_irq_pkg::S_ACK_R: begin
            if (scl_fall) begin
               d.sda_oe = 1'b0;
               d.cnt    = tag_irq_pkg::CNT_ZERO;
               d.st     = tag_irq_pkg::S_RX;
            end
         end
         tag_irq_pkg::S_TX: begin
            if (scl_rise) begin
               d.cnt = q.cnt + 4'h1;
            end else if (scl_fall) begin
               if (q.cnt == tag_irq_pkg::BYTE_BITS) begin
                  d.sda_oe = 1'b0;
                  d.st     = tag_irq_pkg::S_ACK_T;
               end else begin
                  d.sh     = {q.sh[6:0], 1'b0};
                  d.sda_oe = ~q.sh[6];
               end
            end
         end
         tag_irq_pkg::S_ACK_T: begin
            if (scl_rise) begin
               d.acked = ~sda_lvl;
            end else if (scl_fall) begin
               d.cnt = tag_irq_pkg::CNT_ZERO;
               if (q.acked) begin
                  d.sh     = rd_byte(q.ptr, q.flags, q.ena);
                  d.sda_oe = ~d.sh[7];
                  d.ptr    = q.ptr + 16'h0001;
                  d.st     = tag_irq_pkg::S_TX;
               end else begin
                  d.st = tag_irq_pkg::S_IDLE;
               end
            end
         end
         default: begin
            d.sda_oe = 1'b0;
            d.st     = tag_irq_pkg::S_IDLE;
         end
      endcase

      // Start and stop conditions override the byte machine.
      if (scl_lvl && sda_fall) begin
         d.st     = tag_irq_pkg::S_ADDR;
         d.cnt    = tag_irq_pkg::CNT_ZERO;
         d.sda_oe = 1'b0;
      end else if (scl_lvl && sda_rise) begin
         d.st     = tag_irq_pkg::S_IDLE;
         d.sda_oe = 1'b0;
      end

      // Data byte writes: ones clear flags, enables take the byte.
      if (wr_en) begin
         unique case (q.ptr)
            tag_irq_pkg::FLAG_LO_ADDR: clr[7:0]     = rx_byte;
            tag_irq_pkg::FLAG_HI_ADDR: clr[15:8]    = rx_byte;
            tag_irq_pkg::ENA_LO_ADDR:  ena_new[7:0] = rx_byte;
            tag_irq_pkg::ENA_HI_ADDR:  ena_new[15:8] = rx_byte;
            default:                   clr = tag_irq_pkg::FLAG_RESET;
         endcase
      end
      d.ena = ena_new & tag_irq_pkg::IMPL_MASK;

      // Source events; sets are ORed after the clear so they win.
      set[tag_irq_pkg::BIT_CRC]  = events.crc_done;
      set[tag_irq_pkg::BIT_PAR]  = events.parity_err & parity_mode_en;
      set[tag_irq_pkg::BIT_T4]   = events.t4_request;
      set[tag_irq_pkg::BIT_FLD]  = events.field_lost & q.seen;
      set[tag_irq_pkg::BIT_ERR]  = events.generic_error;
      set[tag_irq_pkg::BIT_PREF] = events.prefetch;
      d.flags = ((q.flags & ~clr) | set)
                & tag_irq_pkg::IMPL_MASK;

      // Select arms field-removal reporting until the field goes.
      if (events.tag_select) begin
         d.seen = 1'b1;
      end else if (events.field_lost) begin
         d.seen = 1'b0;
      end

      // Interrupt pin follows the enabled flags with no extra delay.
      d.irq = |(d.flags & d.ena);
   end

   // State register.
   always_ff @(posedge mclk) begin
      if (reset) begin
         q       <= '0;
         q.flags <= tag_irq_pkg::FLAG_RESET;
      end else begin
         q <= d;
      end
   end

   assign sda_o  = q.sda_o;
   assign sda_oe = q.sda_oe;
   assign irq    = q.irq;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   AST_RESV_ZERO: assert property (
      (q.flags & ~tag_irq_pkg::IMPL_MASK) == tag_irq_pkg::FLAG_RESET)
      else $error("reserved flag bit set");
   AST_CLR_ONLY_BY_WRITE: assert property (
      !wr_en |=> (q.flags & $past(q.flags)) == $past(q.flags))
      else $error("flag fell without a write");
   AST_CRC_SET: assert property (
      events.crc_done |=> q.flags[tag_irq_pkg::BIT_CRC])
      else $error("crc flag not set");
   AST_PAR_GATED: assert property (
      !q.flags[tag_irq_pkg::BIT_PAR] && !parity_mode_en
      |=> !q.flags[tag_irq_pkg::BIT_PAR])
      else $error("parity flag set outside checked mode");
   AST_PAR_SET: assert property (
      events.parity_err && parity_mode_en |=> q.flags[tag_irq_pkg::BIT_PAR])
      else $error("parity flag not set");
   AST_T4_SET: assert property (
      events.t4_request |=> q.flags[tag_irq_pkg::BIT_T4])
      else $error("type 4 flag not set");
   AST_FLD_NEEDS_SEL: assert property (
      events.field_lost && !q.seen && !q.flags[tag_irq_pkg::BIT_FLD]
      |=> !q.flags[tag_irq_pkg::BIT_FLD])
      else $error("field flag set without select");
   AST_FLD_SET: assert property (
      events.field_lost && q.seen |=> q.flags[tag_irq_pkg::BIT_FLD])
      else $error("field flag not set after select");
   AST_ERR_SET: assert property (
      events.generic_error |=> q.flags[tag_irq_pkg::BIT_ERR])
      else $error("error flag not set");
   AST_PREF_SET: assert property (
      events.prefetch |=> q.flags[tag_irq_pkg::BIT_PREF])
      else $error("prefetch flag not set");
   AST_IRQ_OR: assert property (
      irq == |(q.flags & q.ena))
      else $error("interrupt pin disagrees with enabled flags");
   AST_RESET_ZERO: assert property (
      disable iff (1'b0) reset |=> q.flags == tag_irq_pkg::FLAG_RESET)
      else $error("flags not zero after reset");

   COV_CLEAR: cover property (wr_en && q.ptr == tag_irq_pkg::FLAG_LO_ADDR);
   COV_IRQ: cover property (!irq ##1 irq);
   COV_READ: cover property (q.st == tag_irq_pkg::S_TX && q.flags != 16'h0000);

endmodule

/* File: logic/tag_irq_pkg.sv */
// Shared constants and types for the tag interrupt flag unit.
// Assumes a single 50 MHz clock and a synchronous active-high reset.
package tag_irq_pkg;

   // ---------------------------------------------------------------
   // Register map (byte addresses on the serial register port)
   // ---------------------------------------------------------------
   localparam logic [15:0] FLAG_LO_ADDR = 16'hFFF8;
   localparam logic [15:0] FLAG_HI_ADDR = 16'hFFF9;
   localparam logic [15:0] ENA_LO_ADDR  = 16'hFFFA;
   localparam logic [15:0] ENA_HI_ADDR  = 16'hFFFB;
   localparam logic [15:0] FLAG_RESET   = 16'h0000;
   localparam logic [15:0] IMPL_MASK    = 16'h01F8;
   localparam logic [7:0]  BYTE_ZERO    = 8'h00;

   // Flag bit positions.
   localparam int BIT_CRC  = 3;
   localparam int BIT_PAR  = 4;
   localparam int BIT_T4   = 5;
   localparam int BIT_FLD  = 6;
   localparam int BIT_ERR  = 7;
   localparam int BIT_PREF = 8;

   // ---------------------------------------------------------------
   // Serial port constants
   // ---------------------------------------------------------------
   // Arbitrary value, chosen only so that the port answers to something.
   localparam logic [6:0] DEV_ADDR   = 7'h28;
   localparam logic [3:0] BYTE_BITS  = 4'h8;
   localparam logic [3:0] CNT_ZERO   = 4'h0;
   localparam logic [1:0] IDX_PTR_HI = 2'h0;
   localparam logic [1:0] IDX_PTR_LO = 2'h1;
   localparam logic [1:0] IDX_DATA   = 2'h2;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic crc_done;
      logic parity_err;
      logic t4_request;
      logic field_lost;
      logic tag_select;
      logic generic_error;
      logic prefetch;
   } tag_events_t;

   typedef enum logic [2:0] {
      S_IDLE, S_ADDR, S_ACK_A, S_RX, S_ACK_R, S_TX, S_ACK_T
   } port_state_t;

   typedef struct packed {
      port_state_t st;
      logic [3:0]  cnt;
      logic [7:0]  sh;
      logic        rw;
      logic [1:0]  bidx;
      logic [15:0] ptr;
      logic [15:0] flags;
      logic [15:0] ena;
      logic        seen;
      logic        irq;
      logic        sda_o;
      logic        sda_oe;
      logic        acked;
   } unit_state_t;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } sync_state_t;

endpackage

/* File: logic/pin_sync.sv */
// Two-flop synchroniser with edge detection for one pin.
// Assumes the pin is asynchronous to mclk and much slower than it.
module pin_sync (
   input  wire logic mclk,
   input  wire logic reset,
   input  wire logic pin,
   output logic      level,
   output logic      rise,
   output logic      fall
);

   tag_irq_pkg::sync_state_t q;
   tag_irq_pkg::sync_state_t d;

   // Shift the pin through; only the second and third stages feed logic.
   always_comb begin
      d    = q;
      d.s1 = pin;
      d.s2 = q.s1;
      d.s3 = q.s2;
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         q <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1};
      end else begin
         q <= d;
      end
   end

   // Level and edges come from the settled stages.
   assign level = q.s2;
   assign rise  = q.s2 & ~q.s3;
   assign fall  = ~q.s2 & q.s3;

endmodule

/* File: test/host_model.sv */
// Host controller model that reaches the flag unit over its two-wire port.
// Assumes the bench resolves the shared data line with a pull-up.
module host_model (
   input  wire logic mclk,
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_drv
);
   timeunit 1ns;
   timeprecision 1ps;

   // ---------------------------------------------------------------
   // Line primitives
   // ---------------------------------------------------------------
   // Both lines idle high, so the clock stands still between frames.
   initial begin
      scl     = 1'b1;
      sda_drv = 1'b1;
   end

   // One quarter of the 160 ns serial period is two device cycles.
   task automatic qtr(input int n);
      repeat (2 * n) @(negedge mclk);
   endtask

   // Data changes only while the clock is low and is read late in high.
   task automatic put_bit(input logic b, output logic r);
      sda_drv = b;
      qtr(1);
      scl = 1'b1;
      qtr(2);
      r = sda_line;
      scl = 1'b0;
      qtr(1);
   endtask

   // A falling data line while the clock is high opens a frame.
   task automatic start();
      sda_drv = 1'b1;
      qtr(1);
      scl = 1'b1;
      qtr(1);
      sda_drv = 1'b0;
      qtr(1);
      scl = 1'b0;
      qtr(1);
   endtask

   // A rising data line while the clock is high closes the frame.
   task automatic stop();
      sda_drv = 1'b0;
      qtr(1);
      scl = 1'b1;
      qtr(1);
      sda_drv = 1'b1;
      qtr(2);
   endtask

   // ---------------------------------------------------------------
   // Byte and register transfers
   // ---------------------------------------------------------------
   // Sends a byte most significant bit first and returns the ack.
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         put_bit(d[i], r);
      end
      put_bit(1'b1, r);
      ack = ~r;
   endtask

   // Receives a byte, then acks it or, on the last one, refuses it.
   task automatic recv_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         put_bit(1'b1, r);
         d[i] = r;
      end
      put_bit(last, r);
   endtask

   // Writes one byte; at a flag address ones in it clear flags, zeros leave them.
   task automatic write_reg(input  logic [15:0] a,
                            input  logic [7:0]  d,
                            output logic [3:0]  acks);
      start();
      send_byte({tag_irq_pkg::DEV_ADDR, 1'b0}, acks[3]);
      send_byte(a[15:8], acks[2]);
      send_byte(a[7:0], acks[1]);
      send_byte(d, acks[0]);
      stop();
   endtask

   // Reads a low and a high byte through the incrementing pointer.
   task automatic read_word(input  logic [15:0] a,
                            output logic [15:0] d,
                            output logic [3:0]  acks);
      start();
      send_byte({tag_irq_pkg::DEV_ADDR, 1'b0}, acks[3]);
      send_byte(a[15:8], acks[2]);
      send_byte(a[7:0], acks[1]);
      start();
      send_byte({tag_irq_pkg::DEV_ADDR, 1'b1}, acks[0]);
      recv_byte(1'b0, d[7:0]);
      recv_byte(1'b1, d[15:8]);
      stop();
   endtask

   // Sends only an address byte and returns whether it was acknowledged.
   task automatic probe(input logic [7:0] a, output logic ack);
      start();
      send_byte(a, ack);
      stop();
   endtask
endmodule

/* File: test/testbench.sv */
// Self-checking bench of the tag interrupt flag unit and its host port.
// Assumes the design package and the host model are compiled before it.
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
   num_errors++; $display("mismatch at %0t: got %h expected %h", \
   $time, got, exp); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   logic                     mclk;
   logic                     reset;
   logic                     scl;
   logic                     sda_drv;
   logic                     sda_line;
   logic                     sda_o;
   logic                     sda_oe;
   logic                     parity_mode_en;
   logic                     irq;
   logic [3:0]               acks;
   tag_irq_pkg::tag_events_t events;
   int                       num_errors;
   int                       checks_done;
   logic [6:0]               evt [7];
   logic [15:0]              expw [7];

   // The data line is pulled up and low while any party pulls it.
   assign sda_line = (sda_oe ? sda_o : 1'b1) & sda_drv;

   tag_interrupt_flag_unit i_tag_interrupt_flag_unit (
      .mclk           (mclk),
      .reset          (reset),
      .scl            (scl),
      .sda_i          (sda_line),
      .sda_o          (sda_o),
      .sda_oe         (sda_oe),
      .events         (events),
      .parity_mode_en (parity_mode_en),
      .irq            (irq)
   );

   host_model i_host_model (
      .mclk     (mclk),
      .sda_line (sda_line),
      .scl      (scl),
      .sda_drv  (sda_drv)
   );

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // The device clock runs at 50 MHz.
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // Register write; every byte must be acknowledged.
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      i_host_model.write_reg(a, d, acks);
      `CHK(acks, 4'hf)
   endtask

   // Register pair read compared against the expected word.
   task automatic rd(input logic [15:0] a, input logic [15:0] exp);
      logic [15:0] w;
      i_host_model.read_word(a, w, acks);
      `CHK(acks, 4'hf)
      `CHK(w, exp)
   endtask

   // Raises the given event inputs for exactly one cycle.
   task automatic ev(input logic [6:0] e);
      @(negedge mclk);
      events = tag_irq_pkg::tag_events_t'(e);
      @(negedge mclk);
      events = '0;
      repeat (2) @(negedge mclk);
   endtask

   // Prints the verdict and ends the run.
   task automatic results();
      if (num_errors == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // A hung handshake is cut short well past the expected run time.
   initial begin
      #500us;
      num_errors++;
      results();
   end

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   // Sources in order crc, parity, type 4, error, select, removal, fetch.
   initial begin
      evt  = '{7'h40, 7'h20, 7'h10, 7'h02, 7'h04, 7'h08, 7'h01};
      expw = '{16'h0008, 16'h0018, 16'h0038, 16'h00b8, 16'h00b8,
               16'h00f8, 16'h01f8};
      reset          = 1'b1;
      parity_mode_en = 1'b0;
      events         = '0;
      num_errors     = 0;
      checks_done    = 0;
      repeat (12) @(negedge mclk);
      reset = 1'b0;
      repeat (8) @(negedge mclk);
      `CHK(irq, 1'b0)
      rd(tag_irq_pkg::FLAG_LO_ADDR, 16'h0000);
      rd(tag_irq_pkg::ENA_LO_ADDR, 16'h0000);
      // Parity off and removal before any select must set nothing.
      ev(7'h20);
      ev(7'h08);
      rd(tag_irq_pkg::FLAG_LO_ADDR, 16'h0000);
      // Each source but select sets its own bit; every source leaves the others alone.
      parity_mode_en = 1'b1;
      for (int i = 0; i < 7; i++) begin
         ev(evt[i]);
         rd(tag_irq_pkg::FLAG_LO_ADDR, expw[i]);
      end
      `CHK(irq, 1'b0)
      // Ones clear chosen flags, zeros and reserved bits change nothing.
      wr(tag_irq_pkg::FLAG_LO_ADDR, 8'h28);
      rd(tag_irq_pkg::FLAG_LO_ADDR, 16'h01d0);
      wr(tag_irq_pkg::FLAG_LO_ADDR, 8'h00);
      wr(tag_irq_pkg::FLAG_HI_ADDR, 8'hff);
      wr(tag_irq_pkg::FLAG_LO_ADDR, 8'h07);
      rd(tag_irq_pkg::FLAG_LO_ADDR, 16'h00d0);
      // Enables keep their reserved bits at zero.
      wr(tag_irq_pkg::ENA_LO_ADDR, 8'hff);
      wr(tag_irq_pkg::ENA_HI_ADDR, 8'hff);
      rd(tag_irq_pkg::ENA_LO_ADDR, 16'h01f8);
      `CHK(irq, 1'b1)
      // Only the enabled parity flag may drive the pin.
      wr(tag_irq_pkg::ENA_LO_ADDR, 8'h10);
      wr(tag_irq_pkg::ENA_HI_ADDR, 8'h00);
      `CHK(irq, 1'b1)
      wr(tag_irq_pkg::FLAG_LO_ADDR, 8'h10);
      `CHK(irq, 1'b0)
      rd(tag_irq_pkg::FLAG_LO_ADDR, 16'h00c0);
      // An error event in the very cycle its clear lands keeps the flag.
      // The clear lands two device cycles after the 36th serial clock fall.
      fork
         wr(tag_irq_pkg::FLAG_LO_ADDR, 8'h80);
         begin
            repeat (36) @(negedge scl);
            repeat (2) @(negedge mclk);
            events = tag_irq_pkg::tag_events_t'(7'h02);
            @(negedge mclk);
            events = '0;
         end
      join
      rd(tag_irq_pkg::FLAG_LO_ADDR, 16'h00c0);
      wr(tag_irq_pkg::ENA_HI_ADDR, 8'h01);
      `CHK(irq, 1'b0)
      ev(7'h01);
      `CHK(irq, 1'b1)
      // An unmapped pair reads zero.
      wr(16'hfffc, 8'hff);
      rd(16'hfffc, 16'h0000);
      rd(tag_irq_pkg::FLAG_LO_ADDR, 16'h01c0);
      // A foreign device address is left unanswered.
      i_host_model.probe({~tag_irq_pkg::DEV_ADDR, 1'b0}, acks[0]);
      `CHK(acks[0], 1'b0)
      // A second reset clears flags, enables and the pin.
      reset = 1'b1;
      repeat (4) @(negedge mclk);
      reset = 1'b0;
      repeat (8) @(negedge mclk);
      `CHK(irq, 1'b0)
      rd(tag_irq_pkg::FLAG_LO_ADDR, 16'h0000);
      rd(tag_irq_pkg::ENA_LO_ADDR, 16'h0000);
      results();
   end
endmodule
